// ---- src/ifs_fifo_flags.sv ----
// raw fifo status flags of the serial controller
// assumes link inputs are produced on linkClk, the rest on ref_clk
`timescale 1ns/10ps
`default_nettype none

module ifs_fifo_flags (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              linkClk,
    input  wire ifs_pkg::ifs_cfg_s  cfg,
    input  wire ifs_pkg::ifs_cpu_s  cpu,
    input  wire ifs_pkg::ifs_link_s link,
    output var  logic [31:0]       rawIrqStatus,
    output var  logic [3:0]        txFifoLevel,
    output var  logic [3:0]        rxFifoLevel
);
    import ifs_pkg::*;

    // ------------------------------------------------------------------
    // link clock side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rstMeta;
        logic rstSync;
        logic rdReqTgl;
        logic txPopTgl;
        logic rxByteTgl;
        logic doneLvl;
        logic activeLvl;
    } ifs_lnk_state_s;

    ifs_lnk_state_s lnk_q;
    ifs_lnk_state_s lnk_d;

    always_comb begin
        lnk_d         = lnk_q;
        lnk_d.rstMeta = srst;
        lnk_d.rstSync = lnk_q.rstMeta;
        if (lnk_q.rstSync) begin
            lnk_d.rdReqTgl  = 1'b0;
            lnk_d.txPopTgl  = 1'b0;
            lnk_d.rxByteTgl = 1'b0;
            lnk_d.doneLvl   = 1'b1;
            lnk_d.activeLvl = 1'b0;
        end else begin
            lnk_d.rdReqTgl  = lnk_q.rdReqTgl ^ link.slaveReadReq;
            lnk_d.txPopTgl  = lnk_q.txPopTgl ^ link.txPop;
            lnk_d.rxByteTgl = lnk_q.rxByteTgl ^ link.rxByte;
            lnk_d.doneLvl   = link.txShiftDone;
            lnk_d.activeLvl = link.fsmActive;
        end
    end

    always_ff @(posedge linkClk) begin
        lnk_q <= lnk_d;
    end

    // ------------------------------------------------------------------
    // controller clock side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       rdReqSy;
        logic [2:0]       txPopSy;
        logic [2:0]       rxByteSy;
        logic [1:0]       doneSy;
        logic [1:0]       activeSy;
        logic [LVL_W-1:0] txLvl;
        logic [LVL_W-1:0] rxLvl;
        logic [31:0]      stat;
    } ifs_ref_state_s;

    ifs_ref_state_s q;
    ifs_ref_state_s d;

    always_comb begin
        logic            rdReqEv;
        logic            txPopEv;
        logic            rxByteEv;
        logic            smActive;
        logic            shiftDone;
        logic            txFull;
        logic            rxFull;
        logic            txPush;
        logic            txPull;
        logic            rxPush;
        logic            rxPull;
        logic            idleOff;
        logic [7:0]      txThr;
        logic [7:0]      rxThr;
        logic [8:0]      rxNeed;
        rdReqEv   = q.rdReqSy[1] ^ q.rdReqSy[2];
        txPopEv   = q.txPopSy[1] ^ q.txPopSy[2];
        rxByteEv  = q.rxByteSy[1] ^ q.rxByteSy[2];
        smActive  = q.activeSy[1];
        shiftDone = q.doneSy[1];
        txFull    = (q.txLvl == TX_FULL_LVL);
        rxFull    = (q.rxLvl == RX_FULL_LVL);
        txPush    = cpu.dataCommandWrite && !txFull;
        txPull    = txPopEv && (q.txLvl != '0);
        rxPush    = rxByteEv && !rxFull;
        rxPull    = cpu.dataCommandRead && (q.rxLvl != '0);
        idleOff   = !smActive && !cfg.internalEnableStatus;
        txThr     = (cfg.transmitThreshold > TX_TL_MAX) ? TX_TL_MAX
                                                        : cfg.transmitThreshold;
        rxThr     = (cfg.receiveThreshold > RECEIVE_THRESHOLD_FIELD_MAX) ? RECEIVE_THRESHOLD_FIELD_MAX
                                                       : cfg.receiveThreshold;
        rxNeed    = {1'b0, rxThr} + 9'h001;

        d = q;
        d.rdReqSy  = {q.rdReqSy[1:0], lnk_q.rdReqTgl};
        d.txPopSy  = {q.txPopSy[1:0], lnk_q.txPopTgl};
        d.rxByteSy = {q.rxByteSy[1:0], lnk_q.rxByteTgl};
        d.doneSy   = {q.doneSy[0], lnk_q.doneLvl};
        d.activeSy = {q.activeSy[0], lnk_q.activeLvl};

        // fifo occupancy
        if (!cfg.enableBit) begin
            d.txLvl = '0;
            d.rxLvl = '0;
        end else begin
            d.txLvl = q.txLvl + LVL_W'(txPush) - LVL_W'(txPull);
            d.rxLvl = q.rxLvl + LVL_W'(rxPush) - LVL_W'(rxPull);
        end

        // read request: set wins over the clear read
        d.stat[BIT_RD_REQ] = rdReqEv ||
            (q.stat[BIT_RD_REQ] && !cpu.readRequestClearRead);

        // transmit level
        if (cfg.enableBit) begin
            d.stat[BIT_TX_EMPTY] = ({4'h0, q.txLvl} <= txThr) &&
                (!cfg.txQualify || shiftDone);
        end else begin
            d.stat[BIT_TX_EMPTY] = smActive ||
                cfg.internalEnableStatus;
        end

        // receive level
        d.stat[BIT_RX_FULL] = cfg.enableBit &&
            ({5'h00, q.rxLvl} >= rxNeed);

        // sticky error flags: set wins, cleared once idle and off
        d.stat[BIT_TX_OVER] = (cfg.enableBit && cpu.dataCommandWrite &&
            txFull) || (q.stat[BIT_TX_OVER] && !idleOff);
        d.stat[BIT_RX_OVER] = (cfg.enableBit && rxByteEv && rxFull &&
            !cfg.receiveFullHoldCtrl) ||
            (q.stat[BIT_RX_OVER] && !idleOff);
        d.stat[BIT_RX_UNDER] = (cpu.dataCommandRead && (q.rxLvl == '0)) ||
            (q.stat[BIT_RX_UNDER] && !idleOff);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q.rdReqSy  <= 3'h0;
            q.txPopSy  <= 3'h0;
            q.rxByteSy <= 3'h0;
            q.doneSy   <= 2'h3;
            q.activeSy <= 2'h0;
            q.txLvl    <= '0;
            q.rxLvl    <= '0;
            q.stat     <= STAT_RESET;
        end else begin
            q <= d;
        end
    end

    assign rawIrqStatus = q.stat;
    assign txFifoLevel  = q.txLvl;
    assign rxFifoLevel  = q.rxLvl;

endmodule // ifs_fifo_flags

`default_nettype wire

// ---- src/ifs_pkg.sv ----
// constants, carriers and bit layout of the fifo status flag block
// assumes one controller clock plus one link clock owned by the bus side
//
// Overview of operation
// - read-request flag sets when addressed as slave by a reading master
// - read-request flag holds until clear register read, then drops to 0
// - qualify 0: transmit-level flag set while level at or below threshold
// - qualify 1: also needs the shifter done with last popped command
// - transmit-level flag clears by itself once level exceeds threshold
// - enable 0 flushes transmit fifo and holds it empty
// - disabled: transmit-level flag reads 1 while a state machine is active
// - disabled, idle and internal enable 0: transmit-level flag forced 0
// - transmit overflow sets on command write into a full transmit fifo
// - overflow/underflow flags hold after disable, clear at idle enable 0
// - receive-level flag follows level above receive threshold
// - enable 0 flushes receive fifo and clears receive-level flag at once
// - byte into full receive fifo is acked, dropped, sets receive overflow
// - receive-full hold set: receive fifo never overflows, no flag
// - receive underflow sets on data read from an empty receive fifo
`default_nettype none
package ifs_pkg;

    localparam int unsigned TX_DEPTH = 8;
    localparam int unsigned RX_DEPTH = 8;
    localparam int unsigned LVL_W    = 4;

    // raw status bit positions
    localparam int unsigned BIT_RX_UNDER = 0;
    localparam int unsigned BIT_RX_OVER  = 1;
    localparam int unsigned BIT_RX_FULL  = 2;
    localparam int unsigned BIT_TX_OVER  = 3;
    localparam int unsigned BIT_TX_EMPTY = 4;
    localparam int unsigned BIT_RD_REQ   = 5;

    localparam logic [31:0] STAT_RESET = 32'h0000_0000;
    localparam logic [LVL_W-1:0] TX_FULL_LVL = LVL_W'(TX_DEPTH);
    localparam logic [LVL_W-1:0] RX_FULL_LVL = LVL_W'(RX_DEPTH);
    localparam logic [7:0] TX_TL_MAX = 8'(TX_DEPTH);
    localparam logic [7:0] RECEIVE_THRESHOLD_FIELD_MAX = 8'(RX_DEPTH - 1);

    // configuration levels, controller clock domain
    typedef struct packed {
        logic       enableBit;
        logic       internalEnableStatus;
        logic       txQualify;
        logic       receiveFullHoldCtrl;
        logic [7:0] transmitThreshold;
        logic [7:0] receiveThreshold;
    } ifs_cfg_s;

    // processor access strobes, controller clock domain
    typedef struct packed {
        logic dataCommandWrite;
        logic dataCommandRead;
        logic readRequestClearRead;
    } ifs_cpu_s;

    // bus-side events and levels, link clock domain
    typedef struct packed {
        logic slaveReadReq;
        logic txPop;
        logic txShiftDone;
        logic rxByte;
        logic fsmActive;
    } ifs_link_s;

endpackage : ifs_pkg

`default_nettype wire

// ---- verif/ifs_fifo_flags_assertions.sv ----
// checker for the fifo status flags
// bound to ifs_fifo_flags by the bench
`timescale 1ns/10ps
`default_nettype none
module ifs_fifo_flags_chk (
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire ifs_pkg::ifs_cfg_s cfg,
    input wire ifs_pkg::ifs_cpu_s cpu,
    input wire logic [31:0]       rawIrqStatus,
    input wire logic [3:0]        txFifoLevel,
    input wire logic [3:0]        rxFifoLevel
);
    import ifs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic [7:0] rxThr = (cfg.receiveThreshold > RECEIVE_THRESHOLD_FIELD_MAX) ? RECEIVE_THRESHOLD_FIELD_MAX
                           : cfg.receiveThreshold;
    wire logic       rxHit = {4'h0, rxFifoLevel} > rxThr;
    wire logic [7:0] txLvl = {4'h0, txFifoLevel};
    rdreq_hold_a: assert property (rawIrqStatus[5] &&
        !cpu.readRequestClearRead |=> rawIrqStatus[5]) else $error("rdreq");
    txover_set_a: assert property (cfg.enableBit &&
        cpu.dataCommandWrite && txFifoLevel == 4'h8 |=> rawIrqStatus[3])
        else $error("txover");
    rxunder_set_a: assert property (cfg.enableBit &&
        cpu.dataCommandRead && rxFifoLevel == 4'h0 |=> rawIrqStatus[0])
        else $error("rxunder");
    txlvl_low_a: assert property (cfg.enableBit && !cfg.txQualify &&
        txLvl <= cfg.transmitThreshold |=> rawIrqStatus[4]) else $error("tx");
    txlvl_high_a: assert property (cfg.enableBit &&
        txLvl > cfg.transmitThreshold |=> !rawIrqStatus[4]) else $error("tx");
    rxlvl_track_a: assert property (cfg.enableBit |=>
        rawIrqStatus[2] == $past(rxHit)) else $error("rx level");
    fifo_flush_a: assert property (!cfg.enableBit |=>
        txFifoLevel == 4'h0 && rxFifoLevel == 4'h0) else $error("flush");
    txlvl_busy_a: assert property (!cfg.enableBit &&
        cfg.internalEnableStatus |=> rawIrqStatus[4]) else $error("busy");
    hold_noover_a: assert property (cfg.receiveFullHoldCtrl &&
        !rawIrqStatus[1] |=> !rawIrqStatus[1]) else $error("hold");
    sticky_clr_a: assert property ($fell(rawIrqStatus[3]) ||
        $fell(rawIrqStatus[1]) || $fell(rawIrqStatus[0]) |->
        !$past(cfg.internalEnableStatus) ||
        !$past(cfg.internalEnableStatus, 2)) else $error("sticky");
    cover property (rawIrqStatus[5]);
    cover property (rawIrqStatus[3] && rawIrqStatus[1]);
    cover property (!cfg.enableBit && rawIrqStatus[4]);
endmodule // ifs_fifo_flags_chk
`default_nettype wire

// ---- verif/ifs_link_model.sv ----
// serial side events on the link clock
// driven by the bench through its tasks
`timescale 1ns/10ps
`default_nettype none
module ifs_link_model (
    input  wire logic               linkClk,
    output var  ifs_pkg::ifs_link_s link
);
    import ifs_pkg::*;
    initial link = 5'h04;
    // one pulse, then quiet so each is seen alone
    task automatic ev(input int k);
        @(posedge linkClk) link[k] <= 1'b1;
        @(posedge linkClk) link[k] <= 1'b0;
        repeat (2) @(posedge linkClk);
    endtask
    task automatic lvl(input int k, input logic v);
        @(posedge linkClk) link[k] <= v;
    endtask
endmodule // ifs_link_model
`default_nettype wire

// ---- verif/ifs_fifo_flags_tb.sv ----
// self-checking bench for the fifo status flags
// assumes the link model drives the serial side
`timescale 1ns/10ps
`default_nettype none
module ifs_fifo_flags_tb;
    import ifs_pkg::*;
    logic        ref_clk = 0, srst = 1, linkClk = 0;
    ifs_cfg_s    cfg = '0;
    ifs_cpu_s    cpu = '0;
    ifs_link_s   link;
    logic [31:0] rawIrqStatus;
    logic [3:0]  txFifoLevel, rxFifoLevel;
    logic [7:0]  rnd = 8'h0a, e;
    logic [7:0]  q[$];
    int          bad_count = 0, tests_run = 0;
    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        #1.3;
        forever #3 linkClk = ~linkClk;
    end
    ifs_fifo_flags dut (.ref_clk, .srst, .linkClk, .cfg, .cpu, .link,
        .rawIrqStatus, .txFifoLevel, .rxFifoLevel);
    ifs_link_model part (.linkClk, .link);
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // notes 0..5 are status bits, 6 the tx level, 7 the rx level
    task automatic want(input int i, input logic [3:0] v);
        q.push_back({i[3:0], v});
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // strobe held n edges, so n back to back accesses
    task automatic hit(input int k, input int n);
        cpu[k] <= 1'b1;
        cyc(n);
        cpu[k] <= 1'b0;
        cyc(1);
    endtask
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t flag mismatch", $time);
        end
    endtask
    task automatic results;
        if (q.size() != 0) begin
            bad_count++;
        end
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(negedge ref_clk) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            case (e[7:4])
                4'h6: check(txFifoLevel, e[3:0]);
                4'h7: check(rxFifoLevel, e[3:0]);
                default: check({3'h0, rawIrqStatus[e[6:4]]}, e[3:0]);
            endcase
        end
    end
    initial begin
        #6000;
        bad_count++;
        results;
    end
    initial begin
        cyc(4);
        srst <= 1'b0;
        rnd = lfsr(rnd);
        cfg <= '{1'b1, 1'b1, 1'b0, 1'b0, {5'h0, rnd[2:0]}, 8'h03};
        cyc(4);
        want(4, 1'b1);
        hit(2, 9);
        cyc(1);
        want(3, 1'b1);
        want(4, 1'b0);
        want(6, 4'h8);
        hit(1, 1);
        want(0, 1'b1);
        part.ev(4);
        cyc(8);
        want(5, 1'b1);
        hit(2, 1);
        hit(0, 1);
        want(5, 1'b0);
        repeat (3) part.ev(3);
        cyc(8);
        want(6, 4'h5);
        want(4, {3'h0, rnd[2:0] >= 3'h5});
        repeat (9) part.ev(1);
        cyc(8);
        want(1, 1'b1);
        want(2, 1'b1);
        want(7, 4'h8);
        part.lvl(0, 1'b1);
        @(posedge ref_clk) cfg.enableBit <= 1'b0;
        cyc(8);
        want(2, 1'b0);
        want(1, 1'b1);
        want(4, 1'b1);
        want(6, 4'h0);
        want(7, 4'h0);
        part.lvl(0, 1'b0);
        @(posedge ref_clk) cfg.internalEnableStatus <= 1'b0;
        cyc(10);
        want(1, 1'b0);
        want(3, 1'b0);
        want(4, 1'b0);
        want(0, 1'b0);
        @(posedge ref_clk) cfg <= '{1'b1, 1'b1, 1'b1, 1'b1, 8'h08, 8'h07};
        part.lvl(2, 1'b0);
        repeat (9) part.ev(1);
        cyc(8);
        want(1, 1'b0);
        want(2, 1'b1);
        want(4, 1'b0);
        want(7, 4'h8);
        part.lvl(2, 1'b1);
        cyc(8);
        want(4, 1'b1);
        cyc(1);
        results;
    end
endmodule // ifs_fifo_flags_tb
bind ifs_fifo_flags ifs_fifo_flags_chk chk (.ref_clk, .srst, .cfg, .cpu,
    .rawIrqStatus, .txFifoLevel, .rxFifoLevel);
`default_nettype wire
